// ==== inc/startup_pkg.sv ====
// Package for the start-up and reset sequencer: register map, field layout and timing.
// Assumes a single 10 MHz clock and a classic Wishbone slave with 32-bit data.
package startup_pkg;
    // Clock rate in kHz and the lock wait in input clock cycles.
    localparam int unsigned CLK_KHZ = 10000;
    localparam int unsigned LOCK_CYCLES = 4096;
    // Width of the lock counter, enough for the wait.
    localparam int LOCK_W = 13;
    // Register byte offsets.
    localparam logic [7:0] OFF_PWR_CTL = 8'h00;
    localparam logic [7:0] OFF_RUN_RST = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    // Field positions in the power management control register.
    localparam int MULT_LSB = 0;
    localparam int MULT_W = 6;
    localparam int DIV_LSB = 8;
    localparam int DIV_W = 2;
    // Run-reset control bit.
    localparam int RUNRST_EN_BIT = 0;
    // Reset values of the multiplier and divider.
    localparam logic [5:0] MULT_RST = 6'h08;
    localparam logic [1:0] DIV_RST = 2'h0;
    // Ratio strap encodings.
    localparam logic [1:0] RATIO_8 = 2'h0;
    localparam logic [1:0] RATIO_32 = 2'h1;
    localparam logic [1:0] RATIO_16 = 2'h2;
    localparam logic [1:0] RATIO_RSVD = 2'h3;
    localparam logic [5:0] MULT_8 = 6'h08;
    localparam logic [5:0] MULT_16 = 6'h10;
    localparam logic [5:0] MULT_32 = 6'h20;

    // Sequencer states, Gray coded along the path.
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOCK = 2'b01,
        ST_RUN = 2'b11
    } seq_state_t;

    // Clock setting carried as one bundle.
    typedef struct packed {
        logic [1:0] div;
        logic [5:0] mult;
    } clk_cfg_t;

    // Wishbone request bundle.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;
endpackage

// ==== src/lock_timer.sv ====
// Lock wait counter: counts input clock cycles after a start and flags expiry.
// Assumes start is a level from the same clock domain.
module lock_timer
    import startup_pkg::*;
#(
    parameter int unsigned CYCLES = LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic done
);
    // Refuse at elaboration a wait that the counter cannot hold.
    if (CYCLES < 1 || CYCLES >= (1 << LOCK_W)) begin : g_bad_cycles
        $error("lock_timer: CYCLES out of range");
    end

    // Cycles counted so far.
    logic [LOCK_W-1:0] cnt_r;

    // Count while started; hold at the end so done stays high.
    always_ff @(posedge clk) begin
        if (!rst_n || !start) begin
            cnt_r <= '0;
        end else if (cnt_r != LOCK_W'(CYCLES)) begin
            cnt_r <= cnt_r + LOCK_W'(1);
        end
    end

    // Done rises once the full count is reached.
    always_ff @(posedge clk) begin
        if (!rst_n || !start) begin
            done <= 1'b0;
        end else begin
            done <= (cnt_r == LOCK_W'(CYCLES - 1)) || done;
        end
    end
endmodule // lock_timer

// ==== src/startup_seq.sv ====
// Start-up sequencer: strap capture, lock wait, boot mode latch and reset pin mode.
// Assumes the board holds hw_rst_n low at power-up and drives the straps before release.
module startup_seq
    import startup_pkg::*;
#(
    parameter int unsigned LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_rst_n,
    input wire logic [1:0] ratio_sel,
    input wire logic [2:0] boot_sel,
    input wire logic rst_pin_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic core_rst_n,
    output logic [5:0] pll_mult,
    output logic [1:0] pll_div,
    output logic [2:0] boot_mode,
    output logic ratio_bad,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic run_rst_req
);
    // Two-flop synchronisers for every pin input.
    // Bit 0 is the board reset, bits 2:1 the ratio straps, bits 5:3 the boot straps
    // and bit 6 the shared reset pin as seen from outside.
    logic [6:0] sync1_r;
    // Second stage; the only stage that any logic reads.
    logic [6:0] sync2_r;
    // Sequencer state.
    seq_state_t state_r;
    // Lock timer expiry; stays high until the sequencer returns to reset.
    logic lock_done;
    // Clock setting held by software.
    clk_cfg_t cfg_r;
    // Run-reset enable bit; when set the pin is floated and read as an input.
    logic runrst_en_r;
    // Bus request bundle, gathered so the decode below reads one name.
    wb_req_t req;
    // A new request this cycle; the ack term keeps one request to one beat.
    logic hit;

    // Strap decode; the reserved code falls back to the slowest ratio.
    // Falling back keeps the core clock low, the safe choice on a bad strap.
    function automatic logic [5:0] ratio_mult(input logic [1:0] code);
        case (code)
            // Eight to one.
            RATIO_8: ratio_mult = MULT_8;
            // Thirty-two to one.
            RATIO_32: ratio_mult = MULT_32;
            // Sixteen to one.
            RATIO_16: ratio_mult = MULT_16;
            // Reserved code; the status bit reports it.
            default: ratio_mult = MULT_8;
        endcase
    endfunction

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};
    assign hit = req.cyc && req.stb && !wb_ack_o;

    // Pins cross into the clock domain; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Cleared stages read as a held board reset until the pin is seen high.
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else begin
            // Both stages shift on every cycle.
            sync1_r <= {rst_pin_in, boot_sel, ratio_sel, hw_rst_n};
            sync2_r <= sync1_r;
        end
    end

    // The sequence starts only from the synchronised release of the reset pin.
    always_ff @(posedge clk) begin
        if (!rst_n || !sync2_r[0]) begin
            state_r <= ST_RESET;
        end else begin
            case (state_r)
                // Leave reset one cycle after the synchronised release.
                ST_RESET: state_r <= ST_LOCK;
                // Hold here until the timer has counted the full lock wait.
                ST_LOCK: state_r <= lock_done ? ST_RUN : ST_LOCK;
                // Stay running until the board pulls reset again.
                ST_RUN: state_r <= ST_RUN;
                // The unused code returns to reset rather than lock up.
                default: state_r <= ST_RESET;
            endcase
        end
    end

    // Counts the lock wait while the sequencer sits in the lock state.
    lock_timer #(
        .CYCLES(LOCK_WAIT)
    ) u_lock (
        .clk(clk),
        .rst_n(rst_n),
        .start(state_r != ST_RESET),
        .done(lock_done)
    );

    // The core stays in reset until the lock wait is over.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Reset holds the core whatever the sequencer says.
            core_rst_n <= 1'b0;
        end else begin
            // Release only in the run state, one cycle after the lock wait ends.
            core_rst_n <= (state_r == ST_RUN);
        end
    end

    // Boot mode is latched while reset is held, so the release freezes it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_mode <= 3'h0;
        end else if (state_r == ST_RESET) begin
            // Tracks the straps while reset is held; outside reset the mode is frozen.
            boot_mode <= sync2_r[5:3];
        end
    end

    // Straps load the clock setting during reset; software writes win later.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r <= '{div: DIV_RST, mult: MULT_RST};
            ratio_bad <= 1'b0;
        end else if (state_r == ST_RESET) begin
            // Under reset the straps decide and any software setting is discarded.
            cfg_r.mult <= ratio_mult(sync2_r[2:1]);
            cfg_r.div <= DIV_RST;
            ratio_bad <= (sync2_r[2:1] == RATIO_RSVD);
        end else if (hit && req.we && req.adr == OFF_PWR_CTL) begin
            // Writes are accepted any time after reset, including the lock wait.
            // Lane 0 carries the multiplier.
            if (req.sel[0]) begin
                cfg_r.mult <= req.dat[MULT_LSB +: MULT_W];
            end
            // Lane 1 carries the divider.
            if (req.sel[1]) begin
                cfg_r.div <= req.dat[DIV_LSB +: DIV_W];
            end
        end
    end

    // Clock setting outputs are registered copies.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Reset values match those of the setting register itself.
            pll_mult <= MULT_RST;
            pll_div <= DIV_RST;
        end else begin
            // The extra register costs a cycle of latency but keeps the outputs glitch free.
            pll_mult <= cfg_r.mult;
            pll_div <= cfg_r.div;
        end
    end

    // Run-reset enable; a hardware reset returns the pin to output.
    always_ff @(posedge clk) begin
        if (!rst_n || state_r == ST_RESET) begin
            // Any board reset hands the pin back to the reset output function.
            runrst_en_r <= 1'b0;
        end else if (hit && req.we && req.adr == OFF_RUN_RST && req.sel[0]) begin
            // Only the lowest bit matters; the rest of the word is ignored.
            runrst_en_r <= req.dat[RUNRST_EN_BIT];
        end
    end

    // Pin drive: output enable is low while driving the reset-out level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Driven low in reset so the board sees reset asserted at once.
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b0;
            run_rst_req <= 1'b0;
        end else begin
            // The pin copies the core reset; the input path is read only when floated.
            rst_pin_out <= core_rst_n;
            rst_pin_oe_n <= runrst_en_r;
            run_rst_req <= runrst_en_r && !sync2_r[6];
        end
    end

    // Wishbone slave: one-cycle ack, unmapped reads return zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            // Ack follows a new request by one cycle and lasts one cycle.
            wb_ack_o <= hit;
            // Data is zero outside the ack cycle, so no stale word lingers on the bus.
            wb_dat_o <= 32'h0000_0000;
            // Status is read only; a write to it simply falls through the decode.
            if (hit && !req.we) begin
                case (req.adr)
                    OFF_PWR_CTL: wb_dat_o <= {22'h0, cfg_r.div, 2'h0, cfg_r.mult};
                    OFF_RUN_RST: wb_dat_o <= {31'h0, runrst_en_r};
                    OFF_STATUS: wb_dat_o <= {24'h0, ratio_bad, boot_mode,
                                             lock_done, core_rst_n, state_r};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // startup_seq

// ==== bench/board_model.sv ====
// Board model: drives the reset pin, the straps and the shared reset pin.
// Assumes the bench changes its commands just after rising edges.
module board_model (
    input wire logic clk,
    input wire logic hold,
    input wire logic pin_low,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic [1:0] ratio_want,
    input wire logic [2:0] boot_want,
    output logic hw_rst_n = 1'b0,
    output logic [1:0] ratio_sel = 2'h0,
    output logic [2:0] boot_sel = 3'h0,
    output wire logic rst_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Reset is low from power-up until the bench lets go.
    // Straps move only under reset, so they are stable at release.
    always @(posedge clk) begin
        hw_rst_n <= !hold;
        if (hold) begin
            ratio_sel <= ratio_want;
            boot_sel <= boot_want;
        end
    end
    // The device drives the wire when enabled, else the board or the pull-up does.
    assign rst_pin_in = !pin_oe_n ? pin_out : !pin_low;
endmodule // board_model

// ==== bench/startup_seq_checker.sv ====
// Assertions on the sequencer ports, bound below the module.
// Assumes one clock and a synchronous active-low reset.
module startup_seq_checker
    import startup_pkg::*;
#(
    parameter int unsigned LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic core_rst_n,
    input wire logic ratio_bad,
    input wire logic rst_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic run_rst_req,
    input wire logic [1:0] ratio_sel,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [5:0] pll_mult
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the board let go; saturates so it cannot wrap.
    logic [15:0] hi_cnt_r;
    always_ff @(posedge clk) begin
        if (!rst_n || !hw_rst_n) begin
            hi_cnt_r <= 16'h0000;
        end else if (hi_cnt_r != 16'hFFFF) begin
            hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
    end
    a_core_held:
    assert property (!hw_rst_n [*5] |-> !core_rst_n) else $error("core out of reset early");
    a_lock_wait:
    assert property ($rose(core_rst_n) |-> hi_cnt_r >= 16'(LOCK_WAIT + 1)
        && hi_cnt_r <= 16'(LOCK_WAIT + 7)) else $error("lock wait length wrong");
    a_strap_ratio:
    assert property ($rose(core_rst_n) |-> ratio_bad == (ratio_sel == RATIO_RSVD) && pll_mult
        == (ratio_sel == RATIO_32 ? MULT_32 : ratio_sel == RATIO_16 ? MULT_16 : MULT_8))
        else $error("startup ratio wrong");
    a_mult_write:
    assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
        && wb_adr_i == OFF_PWR_CTL && core_rst_n |-> ##2 pll_mult == $past(wb_dat_i[5:0], 2))
        else $error("multiplier not written");
    a_reset_out:
    assert property ($past(rst_n) |-> rst_pin_out == $past(core_rst_n))
        else $error("reset out does not follow core reset");
    a_pin_drives:
    assert property (!core_rst_n [*3] |-> !rst_pin_oe_n) else $error("pin not driven in reset");
    a_run_req:
    assert property (run_rst_req == (rst_pin_oe_n && !$past(rst_pin_in, 3)))
        else $error("run reset does not follow the floated pin");
    a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse next cycle");
    c_release: cover property ($rose(core_rst_n));
    c_reserved: cover property ($rose(ratio_bad));
    c_run_req: cover property ($rose(run_rst_req));
endmodule // startup_seq_checker

bind startup_seq startup_seq_checker #(.LOCK_WAIT(LOCK_WAIT)) u_chk (.clk(clk), .rst_n(rst_n),
    .hw_rst_n(hw_rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .core_rst_n(core_rst_n), .ratio_bad(ratio_bad), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .run_rst_req(run_rst_req),
    .ratio_sel(ratio_sel), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .pll_mult(pll_mult));

// ==== bench/startup_seq_test.sv ====
// Self-checking bench for the start-up sequencer beside a board model.
// Assumes the lock wait is shortened to LW cycles.
module startup_seq_test import startup_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned LW = 16;
    // One strap setting and what it should give.
    typedef struct packed {logic [1:0] r; logic [2:0] b; logic [5:0] m; logic bad;} row_t;
    row_t rows [4] = '{'{RATIO_8, 3'h1, MULT_8, 1'b0}, '{RATIO_RSVD, 3'h7, MULT_8, 1'b1},
        '{RATIO_32, 3'h2, MULT_32, 1'b0}, '{RATIO_16, 3'h5, MULT_16, 1'b0}};
    logic clk = 1'b0, rst_n = 1'b0, hold = 1'b1, pin_low = 1'b0;
    logic [1:0] ratio_w = 2'h0, ratio_sel, pll_div;
    logic [2:0] boot_w = 3'h0, boot_sel, boot_mode;
    logic hw_rst_n, rst_pin_in, wb_ack_o, core_rst_n, ratio_bad, rst_pin_out, rst_pin_oe_n;
    logic run_rst_req;
    logic [5:0] pll_mult;
    logic [31:0] wb_dat_o, q;
    wb_req_t req = '0;
    int n_fail = 0, cmp_count = 0, n;
    always #50 clk = ~clk;
    board_model u_board (.clk(clk), .hold(hold), .pin_low(pin_low), .pin_out(rst_pin_out),
        .pin_oe_n(rst_pin_oe_n), .ratio_want(ratio_w), .boot_want(boot_w), .hw_rst_n(hw_rst_n),
        .ratio_sel(ratio_sel), .boot_sel(boot_sel), .rst_pin_in(rst_pin_in));
    startup_seq #(.LOCK_WAIT(LW)) u_dut (.clk(clk), .rst_n(rst_n), .hw_rst_n(hw_rst_n),
        .ratio_sel(ratio_sel), .boot_sel(boot_sel), .rst_pin_in(rst_pin_in), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
        .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_rst_n(core_rst_n),
        .pll_mult(pll_mult), .pll_div(pll_div), .boot_mode(boot_mode), .ratio_bad(ratio_bad),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .run_rst_req(run_rst_req));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle; holds the request until ack is sampled high.
    // Only the watchdog ends a wait for an answer that never comes.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        req <= '{1'b1, 1'b1, we, s, a, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        req <= '0;
        @(posedge clk);
    endtask
    // Board reset pulse, then count cycles until the core is released.
    task automatic board_reset();
        hold <= 1'b1;
        // Two synchroniser stages and the sequencer need time before the pin is back.
        repeat (8) @(posedge clk);
        chk("core held", 32'h0, core_rst_n);
        chk("pin driven", 32'h0, rst_pin_oe_n);
        hold <= 1'b0;
        n = 0;
        while (core_rst_n !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The whole run needs about two hundred cycles; this cuts a hang short.
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            ratio_w <= rows[i].r;
            boot_w <= rows[i].b;
            board_reset();
            chk("lock wait", 32'h1, n >= LW && n <= LW + 10);
            chk("mult", rows[i].m, pll_mult);
            chk("ratio bad", rows[i].bad, ratio_bad);
            chk("boot", rows[i].b, boot_mode);
        end
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h0000_005F, q);
        wb(1'b1, OFF_PWR_CTL, 32'h0000_0315);
        chk("pll", 32'h0000_00D5, {pll_div, pll_mult});
        wb(1'b0, OFF_PWR_CTL, 32'h0);
        chk("pwr read", 32'h0000_0315, q);
        wb(1'b1, OFF_PWR_CTL, 32'h0000_0000, 4'h2);
        chk("div lane", 32'h0000_0015, {pll_div, pll_mult});
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("reset out", 32'h1, {rst_pin_oe_n, rst_pin_out});
        wb(1'b1, OFF_RUN_RST, 32'h0000_0001);
        pin_low <= 1'b1;
        repeat (4) @(posedge clk);
        chk("run reset", 32'h3, {rst_pin_oe_n, run_rst_req});
        pin_low <= 1'b0;
        board_reset();
        chk("run cleared", 32'h0, {rst_pin_oe_n, run_rst_req});
        // A bus reset in mid-run puts the core back in reset and drives the pin low.
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rst core", 32'h0, core_rst_n);
        chk("rst pin", 32'h0, {rst_pin_oe_n, rst_pin_out});
        rst_n <= 1'b1;
        wrap_up();
    end
endmodule // startup_seq_test
